// ---- src/pcp_pkg.sv ----
/*
  Constants, command codes and decode helpers for the peripheral command port.
  Assumes one system clock; shared by the command port and its endpoint bank.
*/
package pcp_pkg;

  // Command codes, low byte of a command phase
  localparam logic [7:0] CMD_BUF_WR_BASE = 8'h00;
  localparam logic [7:0] CMD_BUF_RD_BASE = 8'h10;
  localparam logic [7:0] CMD_CFG_WR_BASE = 8'h20;
  localparam logic [7:0] CMD_CFG_RD_BASE = 8'h30;
  localparam logic [7:0] CMD_STALL_BASE  = 8'h40;
  localparam logic [7:0] CMD_STAT_BASE   = 8'h50;
  localparam logic [7:0] CMD_ADDR_WR     = 8'hb6;
  localparam logic [7:0] CMD_ADDR_RD     = 8'hb7;
  localparam logic [7:0] CMD_MODE_WR     = 8'hb8;
  localparam logic [7:0] CMD_MODE_RD     = 8'hb9;
  localparam logic [7:0] CMD_HW_WR       = 8'hba;
  localparam logic [7:0] CMD_HW_RD       = 8'hbb;
  localparam logic [7:0] CMD_IRQ_WR      = 8'hc2;
  localparam logic [7:0] CMD_IRQ_RD      = 8'hc3;
  localparam logic [7:0] CMD_DMAC_WR     = 8'hf0;
  localparam logic [7:0] CMD_DMAC_RD     = 8'hf1;
  localparam logic [7:0] CMD_DMAN_WR     = 8'hf2;
  localparam logic [7:0] CMD_DMAN_RD     = 8'hf3;
  localparam logic [7:0] CMD_RESET       = 8'hf6;

  // Register lengths in bytes
  localparam logic [2:0] LEN_NONE = 3'h0;
  localparam logic [2:0] LEN_BYTE = 3'h1;
  localparam logic [2:0] LEN_HALF = 3'h2;
  localparam logic [2:0] LEN_WORD = 3'h4;

  // Reset values
  localparam logic [7:0]  RST_ADDR = 8'h00;
  localparam logic [7:0]  RST_MODE = 8'h00;
  localparam logic [15:0] RST_HW   = 16'h0000;
  localparam logic [31:0] RST_IRQ  = 32'h00000000;
  localparam logic [15:0] RST_DMAC = 16'h0000;
  localparam logic [15:0] RST_DMAN = 16'h0000;
  localparam logic [7:0]  RST_CFG  = 8'h00;

  // Endpoint status byte layout, buffer header size
  localparam int unsigned STAT_STALL_BIT = 0;
  localparam logic [16:0] BUF_HDR_BYTES  = 17'h00002;

  typedef enum logic [3:0] {
    K_ILLEGAL, K_CFG, K_ADDR, K_MODE, K_HW, K_IRQ, K_DMAC, K_DMAN,
    K_STAT, K_STALL, K_RESET, K_BWR, K_BRD
  } pcp_kind_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_DATA = 2'b01,
    PH_DONE = 2'b11,
    PH_SKIP = 2'b10
  } pcp_phase_t;

  function automatic pcp_kind_t pcp_kind(input logic [7:0] c);
    pcp_kind_t k;
    k = K_ILLEGAL;
    case (c[7:4])
      CMD_BUF_WR_BASE[7:4]: k = (c[3:0] == 4'h0) ? K_ILLEGAL : K_BWR;
      CMD_BUF_RD_BASE[7:4]: k = (c[3:0] == 4'h1) ? K_ILLEGAL : K_BRD;
      CMD_CFG_WR_BASE[7:4], CMD_CFG_RD_BASE[7:4]: k = K_CFG;
      CMD_STALL_BASE[7:4]:  k = K_STALL;
      CMD_STAT_BASE[7:4]:   k = K_STAT;
      default: begin
        if (c[7:1] == CMD_ADDR_WR[7:1]) k = K_ADDR;
        else if (c[7:1] == CMD_MODE_WR[7:1]) k = K_MODE;
        else if (c[7:1] == CMD_HW_WR[7:1]) k = K_HW;
        else if (c[7:1] == CMD_IRQ_WR[7:1]) k = K_IRQ;
        else if (c[7:1] == CMD_DMAC_WR[7:1]) k = K_DMAC;
        else if (c[7:1] == CMD_DMAN_WR[7:1]) k = K_DMAN;
        else if (c == CMD_RESET) k = K_RESET;
        else k = K_ILLEGAL;
      end
    endcase
    return k;
  endfunction

  // Read direction: odd pair codes, config reads, status, buffer reads
  function automatic logic pcp_is_rd(input logic [7:0] c);
    pcp_kind_t k;
    k = pcp_kind(c);
    case (k)
      K_CFG:   return c[4];
      K_STAT:  return 1'b1;
      K_BRD:   return 1'b1;
      K_BWR:   return 1'b0;
      default: return c[0];
    endcase
  endfunction

  function automatic logic [2:0] pcp_len(input pcp_kind_t k);
    case (k)
      K_CFG, K_ADDR, K_MODE, K_STAT: return LEN_BYTE;
      K_HW, K_DMAC, K_DMAN:          return LEN_HALF;
      K_IRQ:                         return LEN_WORD;
      default:                       return LEN_NONE;
    endcase
  endfunction

endpackage

// ---- src/pcp_fifo.sv ----
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module pcp_fifo #(
  parameter int unsigned WIDTH = 22,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;

  wire do_push = in_valid & in_ready;
  wire do_pop  = out_valid & out_ready;

  assign in_ready  = (count_reg != CW'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];

  wire [AW-1:0] wr_inc = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
  wire [AW-1:0] rd_inc = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);

  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) wr_ptr_reg <= wr_inc;
      if (do_pop) rd_ptr_reg <= rd_inc;
      if (do_push & ~do_pop) count_reg <= count_reg + CW'(1);
      else if (do_pop & ~do_push) count_reg <= count_reg - CW'(1);
    end
  end

  a_fifo_no_over: assert property (@(posedge clk_sys) disable iff (srst)
    count_reg <= CW'(DEPTH)) else $error("FIFO count above depth");
endmodule // pcp_fifo

// ---- src/pcp_ep_bank.sv ----
/*
  Endpoint setup bytes and stall flags for all endpoints.
  Assumes clr covers both the pin reset and the reset command.
*/
`timescale 1ns/100ps
module pcp_ep_bank
  import pcp_pkg::*;
#(
  parameter int unsigned EP_NUM = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              clr,
  input  wire logic              cfg_we,
  input  wire logic [3:0]        cfg_ep,
  input  wire logic [7:0]        cfg_wdata,
  input  wire logic              stall_set,
  input  wire logic [3:0]        stall_ep,
  output logic [EP_NUM*8-1:0]    endpoint_setup,
  output logic [EP_NUM-1:0]      endpoint_stall
);
  logic [7:0]        endpoint_setup_reg [EP_NUM];
  logic [EP_NUM-1:0] stall_reg;

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < EP_NUM; i++) begin
      if (clr) endpoint_setup_reg[i] <= RST_CFG;
      else if (cfg_we && cfg_ep == 4'(i)) endpoint_setup_reg[i] <= cfg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clr) stall_reg <= '0;
    else if (stall_set) stall_reg[stall_ep] <= 1'b1;
  end

  always_comb begin
    for (int i = 0; i < EP_NUM; i++) begin
      endpoint_setup[i*8 +: 8] = endpoint_setup_reg[i];
    end
  end
  assign endpoint_stall = stall_reg;
endmodule // pcp_ep_bank

// ---- src/pcp_cmd_port.sv ----
/*
  Command port of the peripheral controller: command phase, data phase,
  register access, buffer write FIFO and buffer read path.
  Assumes bus strobes are one-cycle pulses synchronous to clk_sys.
*/
`timescale 1ns/100ps
module pcp_cmd_port
  import pcp_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 4,
  parameter int unsigned EP_NUM     = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              bus16_mode,
  input  wire logic              phase_select_pin,
  input  wire logic              bus_wr_stb,
  input  wire logic              bus_rd_stb,
  input  wire logic              bus_rd_act,
  input  wire logic [15:0]       bus_din,
  output logic [15:0]            bus_dout,
  output logic                   bus_doe,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic [15:0]            tx_data,
  output logic                   tx_hi_valid,
  output logic                   tx_last,
  output logic [3:0]             tx_ep,
  output logic                   buf_wr_ready,
  input  wire logic              rx_valid,
  input  wire logic [15:0]       rx_data,
  output logic                   rx_pop,
  output logic [7:0]             device_usb_address,
  output logic [7:0]             operating_mode,
  output logic [15:0]            hw_setup,
  output logic [31:0]            irq_enable,
  output logic [15:0]            dma_setup,
  output logic [15:0]            dma_byte_count,
  output logic [EP_NUM*8-1:0]    endpoint_setup,
  output logic [EP_NUM-1:0]      endpoint_stall
);
  localparam int unsigned FW = 22;

  logic [7:0]  cmd_reg;
  pcp_phase_t  phase_reg;
  pcp_phase_t  phase_next;
  logic [10:0] pos_reg;
  logic [15:0] count_reg;
  logic [15:0] dout_reg;
  logic        doe_reg;
  logic        rx_pop_reg;
  logic [7:0]  device_usb_address_reg;
  logic [7:0]  operating_mode_reg;
  logic [15:0] hw_setup_reg;
  logic [31:0] irq_enable_reg;
  logic [15:0] dma_setup_reg;
  logic [15:0] dma_byte_count_reg;
  logic        fifo_in_ready;
  logic [FW-1:0] fifo_out;

  // Command phase decode straight from the bus low byte
  wire        cmd_stb  = bus_wr_stb & phase_select_pin;
  wire [7:0]  code_in  = bus_din[7:0];
  pcp_kind_t  kind_in;
  pcp_kind_t  kind;
  assign kind_in = pcp_kind(code_in);
  assign kind    = pcp_kind(cmd_reg);
  wire        soft_rst = cmd_stb & (kind_in == K_RESET);
  wire        clr      = srst | soft_rst;
  wire        in_data  = (kind_in != K_ILLEGAL) & (kind_in != K_STALL) & (kind_in != K_RESET);
  wire        cmd_rd   = pcp_is_rd(cmd_reg);
  wire [2:0]  len      = pcp_len(kind);

  // Data phase: only a live command sees bus data
  wire        in_phase = (phase_reg == PH_DATA);
  wire        dat_wr   = bus_wr_stb & ~phase_select_pin & in_phase;
  wire        dat_rd   = bus_rd_stb & ~phase_select_pin & in_phase;
  wire        wr_ok    = dat_wr & ~cmd_rd & ((kind != K_BWR) | fifo_in_ready);
  // No OUT word ready: read refused, no pop, bus_dout holds
  wire        rd_ok    = dat_rd & cmd_rd & ((kind != K_BRD) | rx_valid);
  wire [10:0] step     = bus16_mode ? 11'h002 : 11'h001;

  // Current target value, byte lanes chosen by position
  wire [7:0]  cfg_cur  = endpoint_setup[{cmd_reg[3:0], 3'b000} +: 8];
  // Status byte carries the stall flag only
  wire [7:0]  stat_cur = 8'(endpoint_stall[cmd_reg[3:0]]) << STAT_STALL_BIT;
  wire [31:0] cur_val  = (kind == K_ADDR) ? {24'h000000, device_usb_address_reg} :
                         (kind == K_MODE) ? {24'h000000, operating_mode_reg} :
                         (kind == K_HW)   ? {16'h0000, hw_setup_reg} :
                         (kind == K_IRQ)  ? irq_enable_reg :
                         (kind == K_DMAC) ? {16'h0000, dma_setup_reg} :
                         (kind == K_DMAN) ? {16'h0000, dma_byte_count_reg} :
                         (kind == K_CFG)  ? {24'h000000, cfg_cur} :
                         (kind == K_STAT) ? {24'h000000, stat_cur} :
                         (kind == K_BWR)  ? {16'h0000, count_reg} : 32'h00000000;
  wire [4:0]  sh        = {pos_reg[1:0], 3'b000};
  wire [15:0] din_used  = bus16_mode ? bus_din : {8'h00, bus_din[7:0]};
  wire [31:0] lane_mask = (bus16_mode ? 32'h0000ffff : 32'h000000ff) << sh;
  wire [31:0] merged    = (cur_val & ~lane_mask) | ({16'h0000, din_used} << sh);
  wire [31:0] rd_sh     = cur_val >> sh;
  // Upper byte of a read past the register's bytes reads zero
  wire        rd_hi_ok  = bus16_mode & ((pos_reg + 11'h001) < {8'h00, len});
  wire [15:0] rd_word   = (kind == K_BRD) ? rx_data : {rd_hi_ok ? rd_sh[15:8] : 8'h00, rd_sh[7:0]};
  // Length reached: phase done, later accesses ignored
  wire        reg_last  = (pos_reg + step) >= {8'h00, len};

  // Buffer write: header count, then payload, last word trimmed
  wire        in_hdr    = (pos_reg < 11'h002);
  wire [15:0] cnt_next  = in_hdr ? merged[15:0] : count_reg;
  wire [16:0] total     = {1'b0, cnt_next} + BUF_HDR_BYTES;
  wire [16:0] pos17     = {6'h00, pos_reg};
  wire        push_hi   = bus16_mode & ((pos17 + 17'h00001) < total);
  wire        push_last = (pos17 + {6'h00, step}) >= total;
  wire        buf_push  = wr_ok & (kind == K_BWR);
  wire        done_now  = (kind == K_BWR) ? push_last : (kind == K_BRD) ? 1'b0 : reg_last;
  wire        step_now  = wr_ok | rd_ok;
  wire [FW-1:0] fifo_in = {din_used, push_hi, push_last, cmd_reg[3:0]};

  // Every state takes a new command; illegal codes park in PH_SKIP
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_IDLE, PH_DATA, PH_DONE, PH_SKIP: begin
        if (cmd_stb) begin
          phase_next = in_data ? PH_DATA : (kind_in == K_ILLEGAL) ? PH_SKIP : PH_IDLE;
        end else if (step_now & done_now) begin
          phase_next = PH_DONE;
        end
      end
      default: phase_next = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase_reg <= PH_IDLE;
      cmd_reg   <= 8'h00;
      pos_reg   <= 11'h000;
    end else begin
      phase_reg <= phase_next;
      if (cmd_stb) cmd_reg <= code_in;
      if (cmd_stb) pos_reg <= 11'h000;
      else if (step_now) pos_reg <= pos_reg + step;
    end
  end

  // Header count restarts with every command
  always_ff @(posedge clk_sys) begin
    if (clr | cmd_stb) count_reg <= 16'h0000;
    else if (buf_push & in_hdr) count_reg <= merged[15:0];
  end

  // Registers; the reset command clears them in the same cycle
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      device_usb_address_reg <= RST_ADDR;
      operating_mode_reg     <= RST_MODE;
      hw_setup_reg           <= RST_HW;
      irq_enable_reg         <= RST_IRQ;
      dma_setup_reg          <= RST_DMAC;
      dma_byte_count_reg     <= RST_DMAN;
    end else if (wr_ok) begin
      case (kind)
        K_ADDR:  device_usb_address_reg <= merged[7:0];
        K_MODE:  operating_mode_reg     <= merged[7:0];
        K_HW:    hw_setup_reg           <= merged[15:0];
        K_IRQ:   irq_enable_reg         <= merged;
        K_DMAC:  dma_setup_reg          <= merged[15:0];
        K_DMAN:  dma_byte_count_reg     <= merged[15:0];
        default: ;
      endcase
    end
  end

  // Read data fetched on the strobe: one cycle latency, no prefetch
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dout_reg   <= 16'h0000;
      doe_reg    <= 1'b0;
      rx_pop_reg <= 1'b0;
    end else begin
      if (rd_ok) dout_reg <= rd_word;
      doe_reg    <= bus_rd_act;
      rx_pop_reg <= rd_ok & (kind == K_BRD);
    end
  end

  pcp_ep_bank #(.EP_NUM(EP_NUM)) u_bank (
    .clk_sys        (clk_sys),
    .clr            (clr),
    .cfg_we         (wr_ok & (kind == K_CFG)),
    .cfg_ep         (cmd_reg[3:0]),
    .cfg_wdata      (merged[7:0]),
    .stall_set      (cmd_stb & (kind_in == K_STALL)),
    .stall_ep       (code_in[3:0]),
    .endpoint_setup (endpoint_setup),
    .endpoint_stall (endpoint_stall)
  );

  // Processor cannot be stalled: a full FIFO refuses the word, position holds
  pcp_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (buf_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (fifo_out)
  );

  assign tx_data            = fifo_out[21:6];
  assign tx_hi_valid        = fifo_out[5];
  assign tx_last            = fifo_out[4];
  assign tx_ep              = fifo_out[3:0];
  assign buf_wr_ready       = fifo_in_ready;
  assign bus_dout           = dout_reg;
  assign bus_doe            = doe_reg;
  assign rx_pop             = rx_pop_reg;
  assign device_usb_address = device_usb_address_reg;
  assign operating_mode     = operating_mode_reg;
  assign hw_setup           = hw_setup_reg;
  assign irq_enable         = irq_enable_reg;
  assign dma_setup          = dma_setup_reg;
  assign dma_byte_count     = dma_byte_count_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_cmd_code_taken: assert property (cmd_stb |=> cmd_reg == $past(bus_din[7:0]) && pos_reg == 11'h000)
    else $error("Command code not captured");
  a_stall_at_once: assert property (cmd_stb && bus_din[7:4] == 4'h4 |=> endpoint_stall[$past(bus_din[3:0])])
    else $error("Stall not executed at command");
  a_reset_command: assert property (cmd_stb && bus_din[7:0] == 8'hf6
      |=> irq_enable == 32'h0 && device_usb_address == 8'h0)
    else $error("Reset command left a register set");
  a_read_address: assert property (dat_rd && cmd_reg == 8'hb7 && !bus16_mode
      |=> bus_dout == {8'h00, device_usb_address})
    else $error("Address read returned wrong byte");
  a_lsb_first: assert property (wr_ok && cmd_reg == 8'hc2 && pos_reg == 11'h0 && !bus16_mode
      |=> irq_enable[7:0] == $past(bus_din[7:0]))
    else $error("First byte not least significant");
  a_upper_ignored: assert property (wr_ok && cmd_reg == 8'hb6 && bus16_mode
      |=> device_usb_address == $past(bus_din[7:0]))
    else $error("Upper byte disturbed byte register");
  a_odd_trim: assert property (buf_push && bus16_mode && push_last && !in_hdr && cnt_next[0] |-> !push_hi)
    else $error("Upper byte of odd last word sent");
  a_illegal_quiet: assert property (phase_reg == PH_SKIP && bus_wr_stb && !phase_select_pin
      |=> $stable(device_usb_address) && $stable(irq_enable) && $stable(pos_reg))
    else $error("Illegal command changed state");
  a_pos_held: assert property (!cmd_stb && !step_now |=> $stable(pos_reg) && $stable(cmd_reg))
    else $error("Command or position drifted");
  a_word_step: assert property (wr_ok && bus16_mode && kind == K_HW && pos_reg == 11'h0
      |=> pos_reg == 11'h002 && phase_reg == PH_DONE)
    else $error("Two-byte register not one word cycle");
  // Register, status and buffer paths
  a_mode_write: assert property (wr_ok && cmd_reg == 8'hb8 |=> operating_mode == $past(bus_din[7:0]))
    else $error("Mode byte not written");
  a_hw_word: assert property (wr_ok && cmd_reg == 8'hba && bus16_mode && pos_reg == 11'h0
      |=> hw_setup == $past(bus_din))
    else $error("Hardware setup word not written");
  a_cfg_write: assert property (wr_ok && cmd_reg[7:4] == 4'h2
      |=> endpoint_setup[{$past(cmd_reg[3:0]), 3'b000} +: 8] == $past(bus_din[7:0]))
    else $error("Endpoint setup byte not written");
  a_data_phase_open: assert property (cmd_stb && bus_din[7:4] == 4'h2 |=> phase_reg == PH_DATA)
    else $error("Setup command opened no data phase");
  a_stat_read: assert property (rd_ok && kind == K_STAT
      |=> bus_dout == {15'h0000, $past(endpoint_stall[cmd_reg[3:0]])})
    else $error("Status byte does not show stall flag");
  a_pop_data: assert property (rd_ok && kind == K_BRD |=> rx_pop && bus_dout == $past(rx_data))
    else $error("Buffer read word not taken");
  a_skip_no_access: assert property (phase_reg == PH_SKIP |-> !wr_ok && !rd_ok && !buf_push)
    else $error("Data accepted after illegal code");
  a_buf_end: assert property (buf_push && push_last |=> phase_reg == PH_DONE)
    else $error("Buffer write not closed at its length");

  c_irq_write: cover property (cmd_stb && bus_din[7:0] == 8'hc2 ##[1:20] phase_reg == PH_DONE);
  c_buf_write: cover property (buf_push && push_last && bus16_mode);
  c_buf_read: cover property (rx_pop);
  c_illegal: cover property (cmd_stb && bus_din[7:0] == 8'h11);
  c_stall: cover property (cmd_stb && kind_in == K_STALL);
endmodule // pcp_cmd_port

// ---- tb/pcp_cpu_model.sv ----
/*
  Processor model on the command port's parallel bus: command, write, read.
  Assumes the bench clock; it changes its lines only at the falling edge.
*/
`timescale 1ns/100ps
module pcp_cpu_model (
  input  wire logic        clk_sys,
  output logic             phase_select_pin,
  output logic             bus_wr_stb,
  output logic             bus_rd_stb,
  output logic             bus_rd_act,
  output logic [15:0]      bus_din,
  input  wire logic [15:0] bus_dout
);
  initial begin
    phase_select_pin = 1'b0;
    bus_wr_stb = 1'b0;
    bus_rd_stb = 1'b0;
    bus_rd_act = 1'b0;
    bus_din = 16'h0000;
  end
  // Whole words only in 16-bit mode, short transfers only
  task automatic put(input logic sel, input logic [15:0] d);
    @(negedge clk_sys);
    phase_select_pin = sel;
    bus_din = d;
    bus_wr_stb = 1'b1;
    @(negedge clk_sys);
    bus_wr_stb = 1'b0;
    bus_din = ~d; // Released lines must not keep the last value
  endtask
  task automatic get(output logic [15:0] d);
    @(negedge clk_sys);
    phase_select_pin = 1'b0;
    bus_rd_act = 1'b1;
    bus_rd_stb = 1'b1;
    @(negedge clk_sys);
    bus_rd_stb = 1'b0;
    @(negedge clk_sys);
    d = bus_dout;
    bus_rd_act = 1'b0;
  endtask
endmodule // pcp_cpu_model

// ---- tb/test_peripheral_command_port.sv ----
/*
  Self-checking bench of the command port: registers, commands, buffers.
  Assumes the processor model drives the bus; the bench plays the USB side.
*/
`timescale 1ns/100ps
module test_peripheral_command_port;
  import pcp_pkg::*;
  logic         clk_sys, srst, bus16_mode, psel, wstb, rstb, ract, bus_doe;
  logic         tx_valid, tx_ready, tx_hi_valid, tx_last, buf_wr_ready, rx_valid, rx_pop;
  logic [15:0]  bus_din, bus_dout, tx_data, rx_data, hw_setup, dma_setup, dma_byte_count, endpoint_stall, d;
  logic [3:0]   tx_ep;
  logic [7:0]   device_usb_address, operating_mode;
  logic [31:0]  irq_enable;
  logic [127:0] endpoint_setup;
  int           mismatches, compares, pops;
  pcp_cmd_port dut (.clk_sys(clk_sys), .srst(srst), .bus16_mode(bus16_mode), .phase_select_pin(psel),
    .bus_wr_stb(wstb), .bus_rd_stb(rstb), .bus_rd_act(ract), .bus_din(bus_din), .bus_dout(bus_dout),
    .bus_doe(bus_doe), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_hi_valid(tx_hi_valid),
    .tx_last(tx_last), .tx_ep(tx_ep), .buf_wr_ready(buf_wr_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_pop(rx_pop), .device_usb_address(device_usb_address), .operating_mode(operating_mode),
    .hw_setup(hw_setup), .irq_enable(irq_enable), .dma_setup(dma_setup), .dma_byte_count(dma_byte_count),
    .endpoint_setup(endpoint_setup), .endpoint_stall(endpoint_stall));
  pcp_cpu_model cpu (.clk_sys(clk_sys), .phase_select_pin(psel), .bus_wr_stb(wstb), .bus_rd_stb(rstb),
    .bus_rd_act(ract), .bus_din(bus_din), .bus_dout(bus_dout));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (rx_pop === 1'b1) pops++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic pop();
    @(negedge clk_sys);
    tx_ready = 1'b1;
    @(negedge clk_sys);
    tx_ready = 1'b0;
  endtask
  task automatic t_addr(); // 16-bit, junk upper bytes
    bus16_mode = 1'b1;
    cpu.put(1'b1, {8'h5a, CMD_ADDR_WR});
    cpu.put(1'b0, 16'h7712);
    chk(device_usb_address, 8'h12);
    cpu.put(1'b1, {8'ha5, CMD_ADDR_RD});
    cpu.get(d);
    chk(d[7:0], 8'h12);
    chk(bus_doe, 1'b1);
    cpu.put(1'b1, 16'h0060);
    cpu.put(1'b0, 16'h0099);
    chk(device_usb_address, 8'h12);
    chk(bus_doe, 1'b0);
  endtask
  task automatic t_multi();
    bus16_mode = 1'b0;
    cpu.put(1'b1, {8'h00, CMD_IRQ_WR});
    for (int i = 1; i <= 4; i++) cpu.put(1'b0, 16'(i * 8'h11));
    chk(irq_enable, 32'h44332211);
    cpu.put(1'b1, {8'h00, CMD_MODE_WR});
    cpu.put(1'b0, 16'h0033);
    cpu.put(1'b1, {8'h00, CMD_MODE_RD});
    cpu.get(d);
    chk({operating_mode, d[7:0]}, 16'h3333);
    cpu.put(1'b1, {8'h00, CMD_DMAC_WR});
    cpu.put(1'b0, 16'h0056);
    cpu.put(1'b0, 16'h0078);
    chk(dma_setup, 16'h7856);
    bus16_mode = 1'b1;
    cpu.put(1'b1, {8'h00, CMD_DMAN_WR});
    cpu.put(1'b0, 16'hbeef);
    chk(dma_byte_count, 16'hbeef);
    cpu.put(1'b1, {8'h00, CMD_HW_WR});
    cpu.put(1'b0, 16'h1234);
    cpu.put(1'b0, 16'h5678); // Past the length, ignored
    cpu.put(1'b1, {8'h00, CMD_HW_RD});
    cpu.get(d);
    chk({hw_setup, d}, {16'h1234, 16'h1234});
    cpu.put(1'b1, {8'h00, CMD_RESET});
    chk(irq_enable, RST_IRQ);
    chk({dma_byte_count, dma_setup}, {RST_DMAN, RST_DMAC});
    chk({hw_setup, operating_mode}, {RST_HW, RST_MODE});
  endtask
  task automatic t_ep();
    bus16_mode = 1'b0;
    cpu.put(1'b1, 16'h0041);
    chk(endpoint_stall, 16'h0002);
    cpu.put(1'b1, 16'h0051);
    cpu.get(d);
    chk(d[7:0], 8'h01);
    cpu.put(1'b1, 16'h0052);
    cpu.get(d);
    chk(d[7:0], 8'h00);
    cpu.put(1'b1, 16'h0022);
    cpu.put(1'b0, 16'h0085);
    chk(endpoint_setup[23:16], 8'h85);
    cpu.put(1'b1, 16'h0032);
    cpu.get(d);
    chk(d[7:0], 8'h85);
  endtask
  task automatic t_fifo(); // 8-bit, USB side stalls until full
    logic [7:0] b[5] = '{8'h03, 8'h00, 8'ha1, 8'ha2, 8'ha3};
    cpu.put(1'b1, 16'h0003);
    for (int i = 0; i < 4; i++) cpu.put(1'b0, {8'h00, b[i]});
    chk(buf_wr_ready, 1'b0);
    cpu.put(1'b0, {8'h00, b[4]}); // Refused while full, repeated below
    for (int i = 0; i < 4; i++) begin
      chk({tx_valid, tx_ep, tx_data[7:0]}, {1'b1, 4'h3, b[i]});
      pop();
    end
    cpu.put(1'b0, {8'h00, b[4]});
    chk({tx_last, tx_data[7:0]}, {1'b1, b[4]});
    pop();
    cpu.put(1'b1, 16'h0000);
    cpu.put(1'b0, 16'h0012);
    chk(tx_valid, 1'b0);
  endtask
  task automatic t_odd(); // 16-bit, three bytes
    bus16_mode = 1'b1;
    cpu.put(1'b1, 16'h0001);
    cpu.put(1'b0, 16'h0003);
    cpu.put(1'b0, 16'hbbaa);
    cpu.put(1'b0, 16'h55cc);
    chk({tx_hi_valid, tx_last, tx_data}, {2'b10, 16'h0003});
    pop();
    pop();
    chk({tx_hi_valid, tx_last, tx_data[7:0]}, {2'b01, 8'hcc});
    pop();
  endtask
  task automatic t_rd();
    bus16_mode = 1'b0;
    rx_valid = 1'b1;
    cpu.put(1'b1, 16'h0012);
    cpu.get(d);
    chk(d[7:0], 8'h04);
    cpu.put(1'b1, 16'h0011);
    rx_data = 16'h00aa;
    cpu.get(d);
    chk({d[7:0], pops[3:0]}, {8'h04, 4'h1});
  endtask
  initial begin
    mismatches = 0;
    compares = 0;
    pops = 0;
    srst = 1'b1;
    bus16_mode = 1'b0;
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 16'h0004;
    repeat (16) @(negedge clk_sys);
    srst = 1'b0;
    t_addr();
    t_multi();
    t_ep();
    t_fifo();
    t_odd();
    t_rd();
    end_sim();
  end
  initial begin
    #2000000;
    mismatches++;
    end_sim();
  end
endmodule // test_peripheral_command_port
